// [hpb_port.sv]
// Notes on behaviour
// - the 15-bit host address picks one register or RAM location per access
// - data moves over an 8-bit two-way bus, host drives writes, port reads
// - the address-latch strobe marks access start; the address is captured on it
// - latch strobe is active high in separate-strobe style, low in data-strobe style
// - read and write strobes count only while the low-active select is asserted
// - open-drain low-active service request is pulled low while service is needed
// - separate-strobe style: read strobe low drives the addressed contents on data
// - releasing the read strobe stops driving the data bus
// - data-strobe style: shared strobe qualifies the transfer, direction line gives its way
// - style select 000 separate strobes, 001 data strobe, 111 synchronous; 111 is not served here, the port stays idle
// - separate-strobe style: write strobe low latches data into the addressed location
// - data-strobe style: direction high reads, low writes
// - ready/acknowledge stays in not-ready state to stretch until the access completes
`timescale 1ns/100ps
`default_nettype none
`include "hpb_consts.svh"

module hpb_port (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic [`HPB_STYLE_W-1:0] host_bus_style_select,
	input  wire logic [`HPB_ADDR_W-1:0]  host_addr,
	input  wire logic                    address_latch_strobe,
	input  wire logic                    cs_n,
	input  wire logic                    read_or_data_strobe_n,
	input  wire logic                    write_or_dir,
	input  wire logic [`HPB_DATA_W-1:0]  host_data_in,
	output logic      [`HPB_DATA_W-1:0]  host_data_out,
	output logic                         host_data_oe,
	output logic                         cycle_complete_ack_n,
	output logic                         irq_n_out,
	output logic                         irq_n_oe,
	input  wire logic                    irq_request,
	output logic      [`HPB_ADDR_W-1:0]  reg_addr,
	output logic      [`HPB_DATA_W-1:0]  reg_wdata,
	output logic                         reg_wr_stb,
	output logic                         reg_rd_stb,
	input  wire logic [`HPB_DATA_W-1:0]  reg_rdata,
	input  wire logic                    reg_ack
);
	hpb_strb_if strb ();

	hpb_strobe_decode u_decode (
		.host_bus_style_select (host_bus_style_select),
		.address_latch_strobe  (address_latch_strobe),
		.cs_n                  (cs_n),
		.read_or_data_strobe_n (read_or_data_strobe_n),
		.write_or_dir          (write_or_dir),
		.strb                  (strb.dec)
	);

	hpb_pkg::hpb_state_t          state_q;
	hpb_pkg::hpb_state_t          state_d;
	logic [`HPB_ADDR_W-1:0]       addr_q;
	logic [`HPB_ADDR_W-1:0]       addr_d;
	logic [`HPB_DATA_W-1:0]       rdata_q;
	logic [`HPB_DATA_W-1:0]       rdata_d;
	logic [`HPB_DATA_W-1:0]       wdata_q;
	logic [`HPB_DATA_W-1:0]       wdata_d;
	logic                         rd_stb_q;
	logic                         rd_stb_d;
	logic                         wr_stb_q;
	logic                         wr_stb_d;
	logic                         rd_req;
	logic                         wr_req;
	logic                         busy;
	logic                         rd_hold;
	logic                         wr_hold;

	assign rd_req = strb.sel_on & strb.rd_on;
	assign wr_req = strb.sel_on & strb.wr_on;

	// address group: the latch follows the bus while its strobe is active and holds after release
	always_comb begin
		addr_d = addr_q;
		if (strb.latch_on) begin
			addr_d = host_addr;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_q <= `HPB_ADDR_RST;
		end else begin
			addr_q <= addr_d;
		end
	end

	// data group: the write byte is taken with the request, the read byte on the core's answer
	always_comb begin
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		if ((state_q == hpb_pkg::HPB_IDLE) & ~rd_req & wr_req) begin
			wdata_d = host_data_in;
		end
		if ((state_q == hpb_pkg::HPB_RD_WAIT) & reg_ack) begin
			rdata_d = reg_rdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= `HPB_DATA_RST;
			wdata_q <= `HPB_DATA_RST;
		end else begin
			rdata_q <= rdata_d;
			wdata_q <= wdata_d;
		end
	end

	// access sequencer
	always_comb begin
		state_d  = state_q;
		rd_stb_d = 1'b0;
		wr_stb_d = 1'b0;
		case (state_q)
			hpb_pkg::HPB_IDLE: begin
				if (rd_req) begin
					rd_stb_d = 1'b1;
					state_d  = hpb_pkg::HPB_RD_WAIT;
				end else if (wr_req) begin
					wr_stb_d = 1'b1;
					state_d  = hpb_pkg::HPB_WR_WAIT;
				end
			end
			hpb_pkg::HPB_RD_WAIT: begin
				// an abandoned read still lets the core answer, but nothing is driven
				if (reg_ack) begin
					state_d = rd_req ? hpb_pkg::HPB_RD_DONE : hpb_pkg::HPB_IDLE;
				end
			end
			hpb_pkg::HPB_RD_DONE: begin
				if (!rd_req) begin
					state_d = hpb_pkg::HPB_IDLE;
				end
			end
			hpb_pkg::HPB_WR_WAIT: begin
				// a posted write completes even if the strobe drops early
				if (reg_ack) begin
					state_d = wr_req ? hpb_pkg::HPB_WR_DONE : hpb_pkg::HPB_IDLE;
				end
			end
			hpb_pkg::HPB_WR_DONE: begin
				// one write per strobe: wait for release before the next one
				if (!wr_req) begin
					state_d = hpb_pkg::HPB_IDLE;
				end
			end
			default: begin
				state_d = hpb_pkg::HPB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q  <= hpb_pkg::HPB_IDLE;
			rd_stb_q <= 1'b0;
			wr_stb_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			rd_stb_q <= rd_stb_d;
			wr_stb_q <= wr_stb_d;
		end
	end

	// answers per state; the strobe terms drop the done-state holds in the very cycle the host lets go,
	// so a released data strobe never sees a stale acknowledge
	always_comb begin
		busy    = 1'b0;
		rd_hold = 1'b0;
		wr_hold = 1'b0;
		case (state_q)
			hpb_pkg::HPB_RD_WAIT: begin
				busy = 1'b1;
			end
			hpb_pkg::HPB_WR_WAIT: begin
				busy = 1'b1;
			end
			hpb_pkg::HPB_RD_DONE: begin
				rd_hold = rd_req;
			end
			hpb_pkg::HPB_WR_DONE: begin
				wr_hold = wr_req;
			end
			default: begin
				busy = 1'b0;
			end
		endcase
	end

	assign reg_addr   = addr_q;
	assign reg_wdata  = wdata_q;
	assign reg_rd_stb = rd_stb_q;
	assign reg_wr_stb = wr_stb_q;

	assign host_data_out = rdata_q;
	// drive only once data is valid and while the read is still held
	assign host_data_oe  = rd_hold;

	// separate style: high means ready, low stretches; data-strobe style: low acknowledges
	assign cycle_complete_ack_n = strb.ds_style ? ~(rd_hold | wr_hold) : ~busy;

	assign irq_n_out = 1'b0;
	assign irq_n_oe  = irq_request;
endmodule : hpb_port

`default_nettype wire

// [hpb_consts.svh]
`ifndef HPB_CONSTS_SVH
`define HPB_CONSTS_SVH

// widths of the host pins
`define HPB_ADDR_W        15
`define HPB_DATA_W        8
`define HPB_STYLE_W       3

// bus style select codes
`define HPB_STYLE_SEP     3'h0
`define HPB_STYLE_DS      3'h1
`define HPB_STYLE_SYNC    3'h7

// reset values
`define HPB_ADDR_RST      15'h0000
`define HPB_DATA_RST      8'h00

`endif

// [hpb_pkg.sv]
`default_nettype none
package hpb_pkg;

	typedef enum logic [2:0] {
		HPB_IDLE    = 3'b000,
		HPB_RD_WAIT = 3'b001,
		HPB_RD_DONE = 3'b010,
		HPB_WR_WAIT = 3'b011,
		HPB_WR_DONE = 3'b100
	} hpb_state_t;

endpackage : hpb_pkg
`default_nettype wire

// [hpb_strb_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface hpb_strb_if;
	logic latch_on;
	logic rd_on;
	logic wr_on;
	logic sel_on;
	logic ds_style;

	modport dec (
		output latch_on,
		output rd_on,
		output wr_on,
		output sel_on,
		output ds_style
	);
	modport ctl (
		input latch_on,
		input rd_on,
		input wr_on,
		input sel_on,
		input ds_style
	);
endinterface : hpb_strb_if

`default_nettype wire

// [hpb_strobe_decode.sv]
`timescale 1ns/100ps
`default_nettype none
`include "hpb_consts.svh"

module hpb_strobe_decode (
	input  wire logic [`HPB_STYLE_W-1:0] host_bus_style_select,
	input  wire logic                    address_latch_strobe,
	input  wire logic                    cs_n,
	input  wire logic                    read_or_data_strobe_n,
	input  wire logic                    write_or_dir,
	hpb_strb_if.dec                      strb
);
	logic sep_style;
	logic ds_style;

	// synchronous processor style is not served: both flags stay low and the port sleeps
	assign sep_style = (host_bus_style_select == `HPB_STYLE_SEP);
	assign ds_style  = (host_bus_style_select == `HPB_STYLE_DS);

	always_comb begin
		strb.ds_style = ds_style;
		strb.sel_on   = ~cs_n & (sep_style | ds_style);
		strb.latch_on = (sep_style & address_latch_strobe) |
		                (ds_style & ~address_latch_strobe);
		if (ds_style) begin
			strb.rd_on = ~read_or_data_strobe_n & write_or_dir;
			strb.wr_on = ~read_or_data_strobe_n & ~write_or_dir;
		end else begin
			strb.rd_on = sep_style & ~read_or_data_strobe_n;
			strb.wr_on = sep_style & ~write_or_dir;
		end
	end
endmodule : hpb_strobe_decode

`default_nettype wire

// [hpb_port_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "hpb_consts.svh"
module hpb_port_sva (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [2:0] host_bus_style_select,
	input wire logic       cs_n,
	input wire logic       read_or_data_strobe_n,
	input wire logic [7:0] host_data_out,
	input wire logic       host_data_oe,
	input wire logic       cycle_complete_ack_n,
	input wire logic       reg_wr_stb,
	input wire logic       reg_rd_stb,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq_n_oe,
	input wire logic       irq_request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic stb;
	logic ds;
	assign stb = reg_rd_stb | reg_wr_stb;
	assign ds = host_bus_style_select == `HPB_STYLE_DS;
	sequence sel_strobe_s;
		!cs_n && !read_or_data_strobe_n;
	endsequence
	oe_qual_a: assert property (host_data_oe |-> sel_strobe_s)
		else $error("data bus driven without a selected strobe");
	inert_a: assert property (!(host_bus_style_select inside {3'h0, 3'h1}) |-> cycle_complete_ack_n)
		else $error("ack in an unused style");
	ds_ack_a: assert property (ds && !cycle_complete_ack_n |-> sel_strobe_s)
		else $error("ack without data strobe");
	rd_data_a: assert property ($rose(host_data_oe) |-> host_data_out == $past(reg_rdata))
		else $error("read data differs from core data");
	stb_gap_a: assert property (stb |=> !stb [*2])
		else $error("access strobes too close");
	stb_sel_a: assert property (stb |-> $past(cs_n) == 1'b0)
		else $error("access taken while unselected");
	stb_excl_a: assert property (!(reg_rd_stb && reg_wr_stb))
		else $error("read and write at once");
	irq_a: assert property (irq_n_oe == irq_request)
		else $error("service request pin wrong");
endmodule : hpb_port_sva
bind hpb_port hpb_port_sva hpb_port_sva_i (.clk(clk), .sys_rst(sys_rst),
	.host_bus_style_select(host_bus_style_select), .cs_n(cs_n),
	.read_or_data_strobe_n(read_or_data_strobe_n), .host_data_out(host_data_out),
	.host_data_oe(host_data_oe), .cycle_complete_ack_n(cycle_complete_ack_n),
	.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
	.irq_n_oe(irq_n_oe), .irq_request(irq_request));
`default_nettype wire

// [hpb_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module hpb_core_model (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [14:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr_stb,
	input  wire logic        reg_rd_stb,
	output logic      [7:0]  reg_rdata,
	output logic             reg_ack
);
	logic [7:0]  mem [0:32767];
	logic [14:0] last_addr;
	logic [1:0]  wait_q;
	logic [1:0]  slow_q;
	logic        busy_q;
	int          n_stb;
	// inverse outside ack so a late sample shows up
	assign reg_rdata = reg_ack ? mem[last_addr] : ~mem[last_addr];
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_ack <= 1'b0;
			busy_q <= 1'b0;
			slow_q <= 2'h0;
			n_stb <= 0;
		end else begin
			reg_ack <= busy_q && wait_q == 2'h0;
			if (reg_wr_stb | reg_rd_stb) begin
				n_stb <= n_stb + 1;
				busy_q <= 1'b1;
				wait_q <= slow_q;
				slow_q <= slow_q + 2'h1;
				last_addr <= reg_addr;
				if (reg_wr_stb)
					mem[reg_addr] <= reg_wdata;
			end else if (busy_q) begin
				busy_q <= wait_q != 2'h0;
				wait_q <= wait_q - 2'h1;
			end
		end
	end
endmodule : hpb_core_model
`default_nettype wire

// [hpb_port_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "hpb_consts.svh"
module hpb_port_test;
	logic        clk, sys_rst, latch, cs_n, rds_n, wod, irq_request, oe, ack_n, irq_oe;
	logic        wr_stb, rd_stb, rack, ok, irq_out;
	logic [2:0]  sty;
	logic [14:0] addr, raddr, a;
	logic [7:0]  din, dout, rdata, wdata, q, d;
	int          seed, n_errors, num_checks, n;
	hpb_port hpb_port_i (.clk(clk), .sys_rst(sys_rst), .host_bus_style_select(sty),
		.host_addr(addr), .address_latch_strobe(latch), .cs_n(cs_n),
		.read_or_data_strobe_n(rds_n), .write_or_dir(wod), .host_data_in(din),
		.host_data_out(dout), .host_data_oe(oe), .cycle_complete_ack_n(ack_n),
		.irq_n_out(irq_out), .irq_n_oe(irq_oe), .irq_request(irq_request), .reg_addr(raddr),
		.reg_wdata(wdata), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .reg_rdata(rdata),
		.reg_ack(rack));
	hpb_core_model hpb_core_model_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(raddr),
		.reg_wdata(wdata), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .reg_rdata(rdata),
		.reg_ack(rack));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic access(input logic [2:0] s, input logic sel, input logic wr,
		input logic [14:0] ta, input logic [7:0] dv, input int lim);
		logic is_ds;
		logic low;
		is_ds = s == `HPB_STYLE_DS;
		low = 1'b0;
		ok = 1'b0;
		sty = s;
		cs_n = !sel;
		addr = ta;
		latch = !is_ds;
		@(posedge clk);
		#2;
		latch = is_ds;
		addr = ~ta;
		din = dv;
		wod = !wr;
		rds_n = is_ds ? 1'b0 : wr;
		for (int i = 0; i < lim && !ok; i++) begin
			@(posedge clk);
			#2;
			low |= !ack_n;
			ok = wr ? (is_ds ? !ack_n : low & ack_n) : oe;
		end
		// hold until an edge has seen the completion
		@(posedge clk);
		#2;
		q = dout;
		rds_n = 1'b1;
		wod = 1'b1;
		cs_n = 1'b1;
		din = ~dv;
		#1;
		chk(15'(oe), 15'h0000);
		chk(15'(ack_n), 15'h0001);
		@(posedge clk);
		#2;
	endtask : access
	initial begin
		seed = 88464;
		n_errors = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		sty = `HPB_STYLE_SEP;
		addr = 15'h0000;
		latch = 1'b0;
		cs_n = 1'b1;
		rds_n = 1'b1;
		wod = 1'b1;
		din = 8'h00;
		irq_request = 1'b0;
		repeat (20) @(posedge clk);
		#2;
		sys_rst = 1'b0;
		for (int i = 0; i < 40; i++) begin
			a = $random(seed);
			d = $random(seed);
			if (i < 2) begin
				a = {15{i[0]}};
				d = {8{i[0]}};
			end
			irq_request = $random(seed);
			access(3'($random(seed) & 1), 1'b1, 1'b1, a, d, 50);
			chk(15'(ok), 15'h0001);
			chk(hpb_core_model_i.last_addr, a);
			access(3'($random(seed) & 1), 1'b1, 1'b0, a, 8'h00, 50);
			chk(15'(ok), 15'h0001);
			chk(15'(q), 15'(d));
			chk(15'(irq_oe), 15'(irq_request));
			chk(15'(irq_out), 15'h0000);
			if (ok !== 1'b1)
				give_verdict();
		end
		$display("write and read test done");
		n = hpb_core_model_i.n_stb;
		for (int k = 0; k < 4; k++) begin
			access(k[1] ? `HPB_STYLE_SYNC : {2'b00, k[0]}, k[1], k[0], 15'h0011, 8'h5a, 6);
			chk(15'(ok), 15'h0000);
		end
		chk(15'(hpb_core_model_i.n_stb - n), 15'h0000);
		$display("refused access test done");
		give_verdict();
	end
endmodule : hpb_port_test
`default_nettype wire
